// File: core/pcm_power_clock_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcm_regs.svh"

module pcm_power_clock_ctrl #(
    parameter int WARM_CLOCKS = `PCM_XTAL_WARM_CLOCKS
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rstn,
    // Register port.
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // Core events.
    input  wire logic       ext_irq_serviceable,
    input  wire logic       any_irq,
    input  wire logic       serial_start_bit,
    input  wire logic       tx_buffer_write,
    input  wire logic       supply_warning_irq,
    input  wire logic       powerfail_reset,
    input  wire logic       xtal_osc_started,
    input  wire logic       xtal_tick,
    // Status inputs.
    input  wire logic [2:0] level_in_service,
    input  wire logic [3:0] serial_activity,
    // Clock control outputs.
    output logic      [10:0] clocks_per_cycle,
    output logic            core_from_crystal,
    output logic            crystal_amp_enable,
    output logic            cpu_halted,
    output logic            all_clocks_stopped,
    output logic            bandgap_enable,
    output logic            cycle_strobe
);

    pcm_pkg::pcm_state_type s_q;
    pcm_pkg::pcm_state_type s_d;

    logic        wr_pc;
    logic        wr_ex;
    logic        wr_pm;
    logic        restore;
    logic        wake_stop;
    logic [10:0] div_now;

    assign wr_pc = wr && (addr == `PCM_ADDR_POWER_CONTROL);
    assign wr_ex = wr && (addr == `PCM_ADDR_EXT_FLAG_CLOCK);
    assign wr_pm = wr && (addr == `PCM_ADDR_POWER_MGMT);

    // Serial start detection only reaches us while reception is enabled upstream.
    assign restore = s_q.auto_speed_restore_enable && (ext_irq_serviceable || serial_start_bit || tx_buffer_write);

    // Internal interrupts cannot wake stop since they need clocks.
    assign wake_stop = ext_irq_serviceable || (s_q.bandgap_keep_on && supply_warning_irq);

    always_comb begin
        case (s_q.cd_cur)
            `PCM_CD_DIV64:   div_now = `PCM_DIV_64;
            `PCM_CD_DIV1024: div_now = `PCM_DIV_1024;
            default:         div_now = `PCM_DIV_FAST;
        endcase
    end

    always_comb begin
        s_d = s_q;
        // Machine cycle counter; frozen in stop since all clocking halts.
        if (s_q.mode != pcm_pkg::PCM_STOP) begin
            if (s_q.cyc_cnt >= div_now - 11'h001) begin
                s_d.cyc_cnt = '0;
            end else begin
                s_d.cyc_cnt = s_q.cyc_cnt + 11'h001;
            end
        end
        // Pending divider takes effect at the next cycle boundary, which never comes in stop.
        if (s_q.cd_pend_v && (s_q.mode != pcm_pkg::PCM_STOP) && (s_q.cyc_cnt >= div_now - 11'h001)) begin
            s_d.cd_cur    = s_q.cd_pend;
            s_d.cd_pend_v = 1'b0;
        end
        if (wr_pm) begin
            s_d.auto_speed_restore_enable = wdata[`PCM_PM_SWB_BIT];
            if (wdata[`PCM_PM_XOFF_BIT] == 1'b0) begin
                if (s_q.xoff) begin
                    s_d.xstable  = 1'b0;
                    s_d.warm_cnt = '0;
                end
                s_d.xoff = 1'b0;
            end else if (!s_q.src_sel) begin
                s_d.xoff = 1'b1;
            end
            if (wdata[`PCM_PM_CD_HI:`PCM_PM_CD_LO] == `PCM_CD_FAST) begin
                // Asking for the speed already in force cancels a pending change rather than
                // queueing a new one, so a slow request right behind it is not refused.
                if (s_d.cd_cur == `PCM_CD_FAST) begin
                    s_d.cd_pend_v = 1'b0;
                end else begin
                    s_d.cd_pend   = `PCM_CD_FAST;
                    s_d.cd_pend_v = 1'b1;
                end
            end else if (wdata[`PCM_PM_CD_HI] && s_q.cd_cur == `PCM_CD_FAST && !s_q.cd_pend_v) begin
                s_d.cd_pend   = wdata[`PCM_PM_CD_HI:`PCM_PM_CD_LO];
                s_d.cd_pend_v = 1'b1;
            end
        end
        if (restore) begin
            if (s_d.cd_cur == `PCM_CD_FAST) begin
                s_d.cd_pend_v = 1'b0;
            end else begin
                s_d.cd_pend   = `PCM_CD_FAST;
                s_d.cd_pend_v = 1'b1;
            end
        end
        if (wr_ex) begin
            s_d.bandgap_keep_on          = wdata[`PCM_EX_BGS_BIT];
            s_d.ring_restart = wdata[`PCM_EX_RING_RESTART_SELECT_BIT];
            if (!wdata[`PCM_EX_SRC_BIT]) begin
                s_d.src_sel   = 1'b0;
                s_d.ring_exit = 1'b0;
            end else if (s_q.xstable && !s_q.xoff) begin
                s_d.src_sel = 1'b1;
            end
        end
        // Crystal warm-up counts crystal clocks after oscillator startup.
        if (!s_q.xstable && !s_q.xoff && xtal_osc_started && xtal_tick) begin
            if (s_q.warm_cnt == 17'(WARM_CLOCKS - 1)) begin
                s_d.xstable = 1'b1;
                if (s_q.ring_exit) begin
                    s_d.src_sel   = 1'b1;
                    s_d.ring_exit = 1'b0;
                end
            end else begin
                s_d.warm_cnt = s_q.warm_cnt + 17'h00001;
            end
        end
        case (s_q.mode)
            pcm_pkg::PCM_RUN: begin
                if (wr_pc && wdata[`PCM_PC_STOP_BIT]) begin
                    s_d.mode    = pcm_pkg::PCM_STOP;
                    s_d.xstable = 1'b0;
                end else if (wr_pc && wdata[`PCM_PC_IDLE_BIT]) begin
                    s_d.mode = pcm_pkg::PCM_IDLE;
                end
            end
            pcm_pkg::PCM_IDLE: begin
                if (any_irq) begin
                    s_d.mode = pcm_pkg::PCM_RUN;
                end
            end
            pcm_pkg::PCM_STOP: begin
                s_d.warm_cnt = '0;
                if (wake_stop) begin
                    s_d.mode = pcm_pkg::PCM_RUN;
                    if (s_q.ring_restart) begin
                        s_d.src_sel   = 1'b0;
                        s_d.ring_exit = 1'b1;
                    end
                end
            end
            default: s_d.mode = pcm_pkg::PCM_RUN;
        endcase
        s_d.ring_active = !s_d.src_sel;
        s_d.rdata = 8'h00;
        if (rd) begin
            case (addr)
                `PCM_ADDR_POWER_CONTROL: begin
                    s_d.rdata[`PCM_PC_STOP_BIT] = s_q.mode == pcm_pkg::PCM_STOP;
                    s_d.rdata[`PCM_PC_IDLE_BIT] = s_q.mode == pcm_pkg::PCM_IDLE;
                end
                `PCM_ADDR_EXT_FLAG_CLOCK: begin
                    s_d.rdata[`PCM_EX_SRC_BIT]  = s_q.src_sel;
                    s_d.rdata[`PCM_EX_RING_BIT] = s_q.ring_active;
                    s_d.rdata[`PCM_EX_RING_RESTART_SELECT_BIT] = s_q.ring_restart;
                    s_d.rdata[`PCM_EX_BGS_BIT]  = s_q.bandgap_keep_on;
                end
                `PCM_ADDR_POWER_MGMT: begin
                    s_d.rdata[`PCM_PM_CD_HI:`PCM_PM_CD_LO] = s_q.cd_cur;
                    s_d.rdata[`PCM_PM_SWB_BIT]             = s_q.auto_speed_restore_enable;
                    s_d.rdata[`PCM_PM_XOFF_BIT]            = s_q.xoff;
                end
                `PCM_ADDR_STATUS: s_d.rdata = {level_in_service, s_q.xstable,
                                               serial_activity};
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q.mode         <= pcm_pkg::PCM_RUN;
            s_q.cd_cur       <= `PCM_CD_FAST;
            s_q.cd_pend      <= `PCM_CD_FAST;
            s_q.cd_pend_v    <= 1'b0;
            s_q.cyc_cnt      <= '0;
            s_q.src_sel      <= 1'b1;
            s_q.ring_active  <= 1'b0;
            s_q.ring_restart <= 1'b0;
            s_q.bandgap_keep_on          <= 1'b0;
            s_q.auto_speed_restore_enable          <= 1'b0;
            s_q.xoff         <= 1'b0;
            s_q.xstable      <= 1'b1;
            s_q.warm_cnt     <= '0;
            s_q.ring_exit    <= 1'b0;
            s_q.rdata        <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata              = s_q.rdata;
    assign clocks_per_cycle   = div_now;
    assign core_from_crystal  = s_q.src_sel;
    assign crystal_amp_enable = !s_q.xoff && (s_q.mode != pcm_pkg::PCM_STOP);
    assign cpu_halted         = s_q.mode != pcm_pkg::PCM_RUN;
    assign all_clocks_stopped = s_q.mode == pcm_pkg::PCM_STOP;
    // Reference is always on outside stop; the keep-on bit only matters in stop.
    assign bandgap_enable     = (s_q.mode != pcm_pkg::PCM_STOP) || s_q.bandgap_keep_on;
    assign cycle_strobe       = (s_q.mode != pcm_pkg::PCM_STOP) && (s_q.cyc_cnt == '0);

    // Assertions.
    src_lock_a: assert property (@(posedge clk) disable iff (!rstn)
        (wr_ex && wdata[`PCM_EX_SRC_BIT] && !s_q.xstable && !s_q.src_sel && !restore)
        |=> !s_q.src_sel || $past(s_q.ring_exit))
        else $error("source set before stable");

    ring_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        ##1
        s_q.ring_active == !$past(s_d.src_sel))
        else $error("ring flag wrong");

    slow_only_fast_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.cd_cur == `PCM_CD_DIV64)
        |=> s_q.cd_cur != `PCM_CD_DIV1024)
        else $error("slow to slow");

    xoff_guard_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(s_q.xoff)
        |-> $past(!s_q.src_sel))
        else $error("xoff with crystal");

    stop_clock_a: assert property (@(posedge clk) disable iff (!rstn)
        all_clocks_stopped
        |-> !crystal_amp_enable && !cycle_strobe)
        else $error("clock in stop");

    stop_wake_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.mode == pcm_pkg::PCM_STOP && !wake_stop)
        |=> s_q.mode == pcm_pkg::PCM_STOP)
        else $error("bad stop exit");

    bgap_run_a: assert property (@(posedge clk) disable iff (!rstn)
        !all_clocks_stopped
        |-> bandgap_enable)
        else $error("reference off");

    ring_exit_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.mode == pcm_pkg::PCM_STOP && wake_stop && s_q.ring_restart)
        |=> s_q.ring_active)
        else $error("no ring exit");

    idle_exit_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.mode == pcm_pkg::PCM_IDLE && any_irq)
        |=> s_q.mode == pcm_pkg::PCM_RUN)
        else $error("idle stuck");

    div_decode_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.cd_cur == `PCM_CD_DIV1024)
        |-> clocks_per_cycle == `PCM_DIV_1024)
        else $error("divider decode wrong");

    cyc_bound_a: assert property (@(posedge clk) disable iff (!rstn)
        !all_clocks_stopped
        |-> s_q.cyc_cnt < div_now)
        else $error("cycle count overrun");

    strobe_gap_a: assert property (@(posedge clk) disable iff (!rstn)
        cycle_strobe
        |=> !cycle_strobe)
        else $error("strobes too close");

    div_apply_a: assert property (@(posedge clk) disable iff (!rstn)
        $changed(s_q.cd_cur)
        |-> $past(s_q.cyc_cnt == div_now - 11'h001))
        else $error("divider changed mid cycle");

    slow_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.cd_cur == `PCM_CD_DIV1024)
        |=> s_q.cd_cur != `PCM_CD_DIV64)
        else $error("slow to slow");

    slow_write_a: assert property (@(posedge clk) disable iff (!rstn)
        (wr_pm && wdata[`PCM_PM_CD_HI] && s_q.cd_cur != `PCM_CD_FAST)
        |=> !s_q.cd_pend_v || s_q.cd_pend == `PCM_CD_FAST)
        else $error("slow setting accepted");

    restore_fast_a: assert property (@(posedge clk) disable iff (!rstn)
        restore
        |=> s_q.cd_cur == `PCM_CD_FAST || (s_q.cd_pend_v && s_q.cd_pend == `PCM_CD_FAST))
        else $error("restore lost");

    swb_off_a: assert property (@(posedge clk) disable iff (!rstn)
        !s_q.auto_speed_restore_enable
        |-> !restore)
        else $error("restore while disabled");

    xoff_src_a: assert property (@(posedge clk) disable iff (!rstn)
        s_q.xoff
        |-> !s_q.src_sel)
        else $error("crystal off but selected");

    amp_off_a: assert property (@(posedge clk) disable iff (!rstn)
        s_q.xoff
        |-> !crystal_amp_enable)
        else $error("amplifier left on");

    warm_len_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(s_q.xstable)
        |-> $past(s_q.warm_cnt) == 17'(WARM_CLOCKS - 1))
        else $error("warm-up too short");

    warm_restart_a: assert property (@(posedge clk) disable iff (!rstn)
        $fell(s_q.xoff)
        |-> !s_q.xstable)
        else $error("stable flag not cleared");

    idle_clock_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.mode == pcm_pkg::PCM_IDLE)
        |-> cpu_halted && !all_clocks_stopped)
        else $error("idle clocks wrong");

    stop_enter_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.mode == pcm_pkg::PCM_RUN && wr_pc && wdata[`PCM_PC_STOP_BIT])
        |=> all_clocks_stopped)
        else $error("stop not entered");

    bgap_stop_a: assert property (@(posedge clk) disable iff (!rstn)
        all_clocks_stopped
        |-> bandgap_enable == s_q.bandgap_keep_on)
        else $error("reference wrong in stop");

    warn_wake_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.mode == pcm_pkg::PCM_STOP && s_q.bandgap_keep_on && supply_warning_irq)
        |=> s_q.mode == pcm_pkg::PCM_RUN)
        else $error("warning did not wake");

    crystal_exit_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.mode == pcm_pkg::PCM_STOP && wake_stop && !s_q.ring_restart)
        |=> s_q.src_sel == $past(s_q.src_sel))
        else $error("source moved on exit");

    ring_hand_a: assert property (@(posedge clk) disable iff (!rstn)
        ($past(s_q.ring_exit) && $rose(s_q.xstable))
        |-> s_q.src_sel)
        else $error("no handover");

    ring_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(s_q.src_sel)
        |-> !s_q.ring_active)
        else $error("ring flag late");

    rd_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
        !rd
        |=> rdata == 8'h00)
        else $error("read data not idle");

    cov_stop_c: cover property (@(posedge clk) disable iff (!rstn) s_q.mode == pcm_pkg::PCM_STOP);
    cov_div_c: cover property (@(posedge clk) disable iff (!rstn) s_q.cd_cur == `PCM_CD_DIV1024);
    cov_hand_c: cover property (@(posedge clk) disable iff (!rstn) $fell(s_q.ring_exit) && s_q.src_sel);
    cov_idle_c: cover property (@(posedge clk) disable iff (!rstn) s_q.mode == pcm_pkg::PCM_IDLE);
    cov_ring_c: cover property (@(posedge clk) disable iff (!rstn) s_q.ring_exit && s_q.mode == pcm_pkg::PCM_RUN);

endmodule : pcm_power_clock_ctrl
`default_nettype wire

// File: shared/pcm_regs.svh
`ifndef PCM_REGS_SVH
`define PCM_REGS_SVH
`define PCM_ADDR_POWER_CONTROL   8'h87
`define PCM_ADDR_EXT_FLAG_CLOCK  8'h91
`define PCM_ADDR_POWER_MGMT      8'hc4
`define PCM_ADDR_STATUS          8'hc5
`define PCM_PC_IDLE_BIT          0
`define PCM_PC_STOP_BIT          1
`define PCM_EX_SRC_BIT           3
`define PCM_EX_RING_BIT          2
`define PCM_EX_RING_RESTART_SELECT_BIT          1
`define PCM_EX_BGS_BIT           0
`define PCM_PM_CD_HI             7
`define PCM_PM_CD_LO             6
`define PCM_PM_SWB_BIT           5
`define PCM_PM_XOFF_BIT          3
`define PCM_CD_FAST              2'h1
`define PCM_CD_DIV64             2'h2
`define PCM_CD_DIV1024           2'h3
`define PCM_DIV_FAST             11'h004
`define PCM_DIV_64               11'h040
`define PCM_DIV_1024             11'h400
`define PCM_XTAL_WARM_CLOCKS     65536
`endif

// File: shared/pcm_pkg.sv
package pcm_pkg;
    typedef enum logic [1:0] {
        PCM_RUN  = 2'b00,
        PCM_IDLE = 2'b01,
        PCM_STOP = 2'b11
    } pcm_mode_type;

    typedef struct packed {
        pcm_mode_type mode;
        logic [1:0]   cd_cur;
        logic [1:0]   cd_pend;
        logic         cd_pend_v;
        logic [10:0]  cyc_cnt;
        logic         src_sel;
        logic         ring_active;
        logic         ring_restart;
        logic         bandgap_keep_on;
        logic         auto_speed_restore_enable;
        logic         xoff;
        logic         xstable;
        logic [16:0]  warm_cnt;
        logic         ring_exit;
        logic [7:0]   rdata;
    } pcm_state_type;
endpackage : pcm_pkg

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcm_regs.svh"

module testbench;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  rdata;
    logic [4:0]  ev = 5'h00;
    logic        osc_on = 1'b0;
    logic        tick = 1'b0;
    logic [2:0]  lvl = 3'h0;
    logic [3:0]  ser = 4'h0;
    logic [10:0] cpc;
    logic [4:0]  obs;
    logic        rd_prev = 1'b0;
    logic [7:0]  expect_q[$];
    logic [31:0] seed = 32'd83925;
    int          bad_count = 0;
    int          comparisons = 0;

    // Events: 0 transmit write, 1 start bit, 2 any irq, 3 external irq, 4 supply warning.
    pcm_power_clock_ctrl #(.WARM_CLOCKS(16)) uut (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .ext_irq_serviceable(ev[3]), .any_irq(ev[2]), .serial_start_bit(ev[1]),
        .tx_buffer_write(ev[0]), .supply_warning_irq(ev[4]), .powerfail_reset(1'b0),
        .xtal_osc_started(osc_on), .xtal_tick(tick), .level_in_service(lvl),
        .serial_activity(ser), .clocks_per_cycle(cpc), .core_from_crystal(obs[4]),
        .crystal_amp_enable(obs[3]), .cpu_halted(obs[2]), .all_clocks_stopped(obs[1]),
        .bandgap_enable(obs[0]), .cycle_strobe());

    always #12.5 clk = ~clk;

    // The crystal only runs while its amplifier is on and the part is not stopped.
    always @(posedge clk) begin
        osc_on <= obs[3] === 1'b1 && obs[1] === 1'b0;
        tick   <= osc_on & ~tick;
    end

    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    always @(posedge clk) begin
        if (rd_prev) begin
            check({3'h0, rdata}, {3'h0, expect_q.pop_front()});
        end
        rd_prev <= rd;
    end

    task automatic end_of_test;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        expect_q.push_back(e);
        @(posedge clk);
        rd   <= 1'b0;
    endtask : rd_reg

    // Status inputs come from the shift register so every bit is exercised.
    task automatic rd_status(input logic stable);
        @(posedge clk);
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        lvl <= seed[6:4];
        ser <= seed[3:0];
        rd_reg(`PCM_ADDR_STATUS, {seed[6:4], stable, seed[3:0]});
    endtask : rd_status

    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
    endtask : pulse

    task automatic wait_bit(input int i, input logic v);
        for (int n = 0; n < 3000 && obs[i] !== v; n++) @(posedge clk);
        check({10'h0, obs[i]}, {10'h0, v});
        if (obs[i] !== v) end_of_test();
    endtask : wait_bit

    task automatic wait_cpc(input logic [10:0] e);
        for (int n = 0; n < 3000 && cpc !== e; n++) @(posedge clk);
        check(cpc, e);
        if (cpc !== e) end_of_test();
    endtask : wait_cpc

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(`PCM_ADDR_EXT_FLAG_CLOCK, 8'h08);
        rd_reg(`PCM_ADDR_POWER_MGMT, 8'h40);
        rd_reg(8'h55, 8'h00);
        rd_status(1'b1);
        check({10'h0, obs[0]}, 11'h001);
        check(cpc, `PCM_DIV_FAST);
        $display("Test reset values done");
        wr_reg(`PCM_ADDR_POWER_MGMT, 8'h80);
        check(cpc, `PCM_DIV_FAST);
        wait_cpc(`PCM_DIV_64);
        wr_reg(`PCM_ADDR_POWER_MGMT, 8'hc0);
        rd_reg(`PCM_ADDR_POWER_MGMT, 8'h80);
        wr_reg(`PCM_ADDR_POWER_MGMT, 8'h40);
        wait_cpc(`PCM_DIV_FAST);
        $display("Test divider done");
        wr_reg(`PCM_ADDR_POWER_MGMT, 8'h60);
        for (int i = 0; i < 4; i++) begin
            wr_reg(`PCM_ADDR_POWER_MGMT, 8'he0);
            wait_cpc(`PCM_DIV_1024);
            pulse(i == 2 ? 3 : i);
            wait_cpc(`PCM_DIV_FAST);
        end
        rd_reg(`PCM_ADDR_POWER_MGMT, 8'h60);
        wr_reg(`PCM_ADDR_POWER_MGMT, 8'h40);
        $display("Test restore done");
        wr_reg(`PCM_ADDR_POWER_CONTROL, 8'h01);
        wait_bit(2, 1'b1);
        check({10'h0, obs[1]}, 11'h000);
        pulse(2);
        wait_bit(2, 1'b0);
        $display("Test idle done");
        wr_reg(`PCM_ADDR_EXT_FLAG_CLOCK, 8'h00);
        wait_bit(4, 1'b0);
        rd_reg(`PCM_ADDR_EXT_FLAG_CLOCK, 8'h04);
        wr_reg(`PCM_ADDR_POWER_MGMT, 8'h48);
        wait_bit(3, 1'b0);
        wr_reg(`PCM_ADDR_POWER_MGMT, 8'h40);
        rd_status(1'b0);
        wr_reg(`PCM_ADDR_EXT_FLAG_CLOCK, 8'h08);
        rd_reg(`PCM_ADDR_EXT_FLAG_CLOCK, 8'h04);
        repeat (80) @(posedge clk);
        rd_status(1'b1);
        wr_reg(`PCM_ADDR_EXT_FLAG_CLOCK, 8'h08);
        wait_bit(4, 1'b1);
        $display("Test source done");
        wr_reg(`PCM_ADDR_EXT_FLAG_CLOCK, 8'h0b);
        wr_reg(`PCM_ADDR_POWER_CONTROL, 8'h02);
        wait_bit(1, 1'b1);
        check({10'h0, obs[0]}, 11'h001);
        pulse(4);
        wait_bit(1, 1'b0);
        check({10'h0, obs[4]}, 11'h000);
        rd_reg(`PCM_ADDR_EXT_FLAG_CLOCK, 8'h07);
        wait_bit(4, 1'b1);
        rd_reg(`PCM_ADDR_EXT_FLAG_CLOCK, 8'h0b);
        $display("Test ring restart done");
        wr_reg(`PCM_ADDR_EXT_FLAG_CLOCK, 8'h08);
        wr_reg(`PCM_ADDR_POWER_CONTROL, 8'h02);
        wait_bit(1, 1'b1);
        check({10'h0, obs[0]}, 11'h000);
        pulse(2);
        pulse(4);
        repeat (4) @(posedge clk);
        check({10'h0, obs[1]}, 11'h001);
        pulse(3);
        wait_bit(1, 1'b0);
        check({10'h0, obs[4]}, 11'h001);
        $display("Test default stop done");
        repeat (4) @(posedge clk);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
